// ===== logic/vsc_pkg.sv
package vsc_pkg;
    localparam int VSC_FRAME_BITS = 40;
    localparam int VSC_BYTE_BITS = 8;
    localparam int VSC_CNT_W = 6;
    localparam int VSC_NUM_CH = 8;
    localparam int VSC_CODE_W = 4;
    localparam int VSC_NUM_CW = 10;
    // control byte field positions
    localparam int VSC_BIT_START = 0;
    localparam int VSC_BIT_WR = 1;
    localparam int VSC_BIT_PWD = 2;
    localparam int VSC_BIT_ATTEN_LO = 3;
    localparam int VSC_BIT_ATTEN_HI = 4;
    localparam int VSC_BIT_MODE = 5;
    localparam int VSC_BIT_PG_LO = 6;
    localparam int VSC_BIT_PG_HI = 7;
    localparam int VSC_DATA_LSB = 8;
    localparam int VSC_CH78_LSB = 32;
    // reset values
    localparam logic VSC_RST_PWD = 1'b1;
    localparam logic VSC_RST_MODE = 1'b0;
    localparam logic [1:0] VSC_RST_ATTEN = 2'h0;
    localparam logic [1:0] VSC_RST_GAIN = 2'h0;
    localparam logic [3:0] VSC_RST_CODE = 4'hF;
    localparam logic [7:0] VSC_RST_CH78 = 8'hFF;
    localparam logic [5:0] VSC_LAST_BIT = 6'h27;
    // decoded settings, in tenths of a dB
    localparam logic [9:0] VSC_ATTEN_00 = 10'h122;
    localparam logic [9:0] VSC_ATTEN_01 = 10'h14A;
    localparam logic [9:0] VSC_ATTEN_10 = 10'h16D;
    localparam logic [9:0] VSC_ATTEN_11 = 10'h190;
    localparam logic [9:0] VSC_GAIN_00 = 10'h0FA;
    localparam logic [9:0] VSC_GAIN_01 = 10'h12C;
    localparam logic [9:0] VSC_GAIN_10 = 10'h15E;
    localparam logic [9:0] VSC_GAIN_11 = 10'h190;
    localparam logic [3:0] VSC_CODE_MAX_CW = 4'h9;

    typedef enum logic [1:0] {
        VSC_IDLE = 2'b01,
        VSC_SHIFT = 2'b10
    } vsc_state_t;
endpackage

// ===== logic/vsc_cfg_store.sv
`timescale 1ns/1ns
// latched configuration words, each loaded whole on its own load pulse
module vsc_cfg_store
    import vsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load_ctrl,
    input wire logic i_load_data,
    input wire logic [7:0] i_ctrl,
    input wire logic [31:0] i_data,
    output logic [7:0] o_ctrl,
    output logic [31:0] o_data
);
    logic [7:0] ctrl_q;
    logic [31:0] data_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= {VSC_RST_GAIN, VSC_RST_MODE, VSC_RST_ATTEN, VSC_RST_PWD, 2'h0};
            data_q <= {VSC_NUM_CH{VSC_RST_CODE}};
        end else begin
            if (i_load_ctrl) begin
                ctrl_q <= i_ctrl;
            end
            if (i_load_data) begin
                data_q <= i_data;
            end
        end
    end

    assign o_ctrl = ctrl_q;
    assign o_data = data_q;
endmodule

// ===== logic/vsc_serial_port.sv
`timescale 1ns/1ns
// Overview of operation
// - each transfer is exactly forty bits, five bytes of eight
// - data comes in on its own input, goes out on its own output
// - read-back bits leave in the same order they were written
// - read-back comes from the shift path, not the latched settings
// - serial output always shows shift-path data, no enable needed
// - a read frame does not latch the routing bytes
// - a read frame still latches the control byte settings
// - works with select tied low; start bit and count bound frames
// - attenuation code picks 29, 33, 36.5 or 40 dB maximum
// - gain code picks 25, 30, 35 or 40 dB
// - routing code 0 to 9 sends channel to that output
// - routing codes 10 to 15 disconnect channel, tie to supply
// - routing decode applies to every nibble of bytes two to five
// - byte five: channel 7 in low nibble, channel 8 in high
// - first one after select low is the start bit
// - control bit two powers down; power-down after reset
// - bits 3-4 attenuation, bit 5 mode, bits 6-7 gain
module vsc_serial_port
    import vsc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_DIN,
    output logic O_DOUT,
    output logic O_POWER_DOWN,
    output logic O_GAIN_RAMP_MODE,
    output logic [1:0] O_ATTEN_RANGE_FIELD,
    output logic [1:0] O_POST_AMP_GAIN,
    output logic [9:0] O_MAX_ATTEN_TENTH_DB,
    output logic [9:0] O_POST_AMP_GAIN_TENTH_DB,
    output logic [31:0] O_ROUTING_CODES,
    output logic [79:0] O_CW_CONNECT,
    output logic [7:0] O_CH_TIED_SUPPLY,
    output logic [7:0] O_CROSSPOINT_ROUTING_CH7_CH8
);
    // ---------------- link domain (serial clock) ----------------
    // the serial clock stops outside frames, so the frame done event is a
    // toggle that the system domain picks up, and the frame word is held
    // stable until the next frame's last bit.
    vsc_state_t state_q;
    vsc_state_t state_d;
    logic [VSC_CNT_W-1:0] cnt_q;
    logic [VSC_CNT_W-1:0] cnt_d;
    logic [VSC_FRAME_BITS-1:0] shift_q;
    logic [VSC_FRAME_BITS-1:0] shift_d;
    logic [VSC_FRAME_BITS-1:0] frame_q;
    logic done_tgl_q;
    logic link_rst_s1_q;
    logic link_rst_q;

    wire start_seen = (state_q == VSC_IDLE) && I_DIN && !I_CS_N;
    wire last_bit = (state_q == VSC_SHIFT) && (cnt_q == VSC_LAST_BIT);
    wire [VSC_FRAME_BITS-1:0] shift_in = {I_DIN, shift_q[VSC_FRAME_BITS-1:1]};

    // system reset carried into the link domain as a level
    always_ff @(posedge I_SCLK) begin
        link_rst_s1_q <= I_SYS_RST;
        link_rst_q <= link_rst_s1_q;
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        unique case (state_q)
            VSC_IDLE: begin
                if (start_seen) begin
                    state_d = VSC_SHIFT;
                    cnt_d = 6'h1;
                    shift_d = shift_in;
                end
            end
            VSC_SHIFT: begin
                shift_d = shift_in;
                if (last_bit) begin
                    state_d = VSC_IDLE;
                    cnt_d = 6'h0;
                end else begin
                    cnt_d = cnt_q + 6'h1;
                end
            end
            default: begin
                state_d = VSC_IDLE;
                cnt_d = 6'h0;
            end
        endcase
    end

    // select high clears the count at once: the serial clock may not run
    // again before the next frame, so an aborted frame never completes
    always_ff @(posedge I_SCLK or posedge I_CS_N) begin
        if (I_CS_N) begin
            state_q <= VSC_IDLE;
            cnt_q <= 6'h0;
        end else if (link_rst_q) begin
            state_q <= VSC_IDLE;
            cnt_q <= 6'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // shift path is not cleared by select, so read-back sees the last frame
    always_ff @(posedge I_SCLK) begin
        if (link_rst_q) begin
            shift_q <= '0;
            frame_q <= '0;
            done_tgl_q <= 1'b0;
        end else begin
            if (state_q == VSC_SHIFT || start_seen) begin
                shift_q <= shift_d;
            end
            if (last_bit) begin
                frame_q <= shift_in;
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // output follows the shift path with no enable
    assign O_DOUT = shift_q[0];

    // ---------------- system domain ----------------
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic [VSC_FRAME_BITS-1:0] frame_s_q;
    logic load_q;
    logic [7:0] ctrl_w;
    logic [31:0] data_w;
    logic [7:0] ctrl_nx;
    logic [31:0] data_nx;
    logic [9:0] atten_db_q;
    logic [9:0] gain_db_q;
    logic [79:0] cw_connect_q;
    logic [7:0] tied_q;
    wire [79:0] cw_connect_d;
    wire [7:0] tied_d;

    // frame_q is stable long before the toggle is seen two flops later
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            load_q <= 1'b0;
            frame_s_q <= '0;
        end else begin
            tgl_s1_q <= done_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            load_q <= tgl_s2_q ^ tgl_s3_q;
            if (tgl_s2_q ^ tgl_s3_q) begin
                frame_s_q <= frame_q;
            end
        end
    end

    wire wr_sel = frame_s_q[VSC_BIT_WR];
    wire load_ctrl = load_q;
    wire load_data = load_q && wr_sel;

    vsc_cfg_store u_store (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_load_ctrl(load_ctrl),
        .i_load_data(load_data),
        .i_ctrl(frame_s_q[VSC_BYTE_BITS-1:0]),
        .i_data(frame_s_q[VSC_FRAME_BITS-1:VSC_DATA_LSB]),
        .o_ctrl(ctrl_w),
        .o_data(data_w)
    );

    function automatic logic [9:0] atten_db(input logic [1:0] code);
        unique case (code)
            2'h0: atten_db = VSC_ATTEN_00;
            2'h1: atten_db = VSC_ATTEN_01;
            2'h2: atten_db = VSC_ATTEN_10;
            default: atten_db = VSC_ATTEN_11;
        endcase
    endfunction

    function automatic logic [9:0] gain_db(input logic [1:0] code);
        unique case (code)
            2'h0: gain_db = VSC_GAIN_00;
            2'h1: gain_db = VSC_GAIN_01;
            2'h2: gain_db = VSC_GAIN_10;
            default: gain_db = VSC_GAIN_11;
        endcase
    endfunction

    // next settings, as the store holds them after this edge; decoded
    // outputs register from these so they move on the same edge
    assign ctrl_nx = I_SYS_RST ?
        {VSC_RST_GAIN, VSC_RST_MODE, VSC_RST_ATTEN, VSC_RST_PWD, 2'h0} :
        (load_ctrl ? frame_s_q[VSC_BYTE_BITS-1:0] : ctrl_w);
    assign data_nx = I_SYS_RST ? {VSC_NUM_CH{VSC_RST_CODE}} :
        (load_data ? frame_s_q[VSC_FRAME_BITS-1:VSC_DATA_LSB] : data_w);

    always_ff @(posedge I_CLK) begin
        atten_db_q <= atten_db(ctrl_nx[VSC_BIT_ATTEN_HI:VSC_BIT_ATTEN_LO]);
        gain_db_q <= gain_db(ctrl_nx[VSC_BIT_PG_HI:VSC_BIT_PG_LO]);
        cw_connect_q <= cw_connect_d;
        tied_q <= tied_d;
    end

    assign O_POWER_DOWN = ctrl_w[VSC_BIT_PWD];
    assign O_ATTEN_RANGE_FIELD = ctrl_w[VSC_BIT_ATTEN_HI:VSC_BIT_ATTEN_LO];
    assign O_GAIN_RAMP_MODE = ctrl_w[VSC_BIT_MODE];
    assign O_POST_AMP_GAIN = ctrl_w[VSC_BIT_PG_HI:VSC_BIT_PG_LO];
    assign O_MAX_ATTEN_TENTH_DB = atten_db_q;
    assign O_POST_AMP_GAIN_TENTH_DB = gain_db_q;
    assign O_ROUTING_CODES = data_w;
    assign O_CROSSPOINT_ROUTING_CH7_CH8 = data_w[31:24];
    assign O_CW_CONNECT = cw_connect_q;
    assign O_CH_TIED_SUPPLY = tied_q;

    // every nibble decodes the same way
    genvar ch;
    generate
        for (ch = 0; ch < VSC_NUM_CH; ch++) begin : g_route
            wire [3:0] code = data_nx[ch*VSC_CODE_W +: VSC_CODE_W];
            wire routed = code <= VSC_CODE_MAX_CW;
            assign tied_d[ch] = !routed;
            for (genvar k = 0; k < VSC_NUM_CW; k++) begin : g_cw
                assign cw_connect_d[ch*VSC_NUM_CW + k] = routed && (code == 4'(k));
            end
        end
    endgenerate
endmodule

// ===== sim/vsc_serial_port_monitor.sv
`timescale 1ns/1ns
module vsc_serial_port_monitor (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CS_N,
    input wire logic O_POWER_DOWN,
    input wire logic [1:0] O_ATTEN_RANGE_FIELD,
    input wire logic [1:0] O_POST_AMP_GAIN,
    input wire logic [9:0] O_MAX_ATTEN_TENTH_DB,
    input wire logic [9:0] O_POST_AMP_GAIN_TENTH_DB,
    input wire logic [31:0] O_ROUTING_CODES,
    input wire logic [79:0] O_CW_CONNECT,
    input wire logic [7:0] O_CH_TIED_SUPPLY,
    input wire logic [7:0] O_CROSSPOINT_ROUTING_CH7_CH8
);
    logic [79:0] cw_exp;
    logic [7:0] tie_exp;
    logic [3:0] idle_q;
    logic [3:0] idle_d;
    logic [9:0] atab [4] = '{10'h122, 10'h14A, 10'h16D, 10'h190};
    logic [9:0] gtab [4] = '{10'h0FA, 10'h12C, 10'h15E, 10'h190};
    always_comb begin
        cw_exp = '0;
        for (int ch = 0; ch < 8; ch++) begin
            tie_exp[ch] = O_ROUTING_CODES[ch*4+:4] > 4'h9;
            if (!tie_exp[ch])
                cw_exp[ch*10+O_ROUTING_CODES[ch*4+:4]] = 1'b1;
        end
    end
    // settings may lag a frame end by up to five cycles
    assign idle_d = !I_CS_N && idle_q != 4'hF ? idle_q : (I_CS_N ? idle_q + 4'h1 : 4'h0);
    always_ff @(posedge I_CLK) begin
        idle_q <= I_SYS_RST || !I_CS_N ? 4'h0 : (idle_q == 4'hF ? idle_q : idle_d);
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    chk_atten_decode: assert property (O_MAX_ATTEN_TENTH_DB == atab[O_ATTEN_RANGE_FIELD])
        else $error("attenuation decode wrong");
    chk_gain_decode: assert property (O_POST_AMP_GAIN_TENTH_DB == gtab[O_POST_AMP_GAIN])
        else $error("gain decode wrong");
    chk_cw_route: assert property (O_CW_CONNECT == cw_exp)
        else $error("output routing wrong");
    chk_supply_tie: assert property (O_CH_TIED_SUPPLY == tie_exp)
        else $error("supply tie wrong");
    chk_byte5_map: assert property (O_CROSSPOINT_ROUTING_CH7_CH8 == O_ROUTING_CODES[31:24])
        else $error("byte five mismatch");
    chk_reset_state: assert property ($fell(I_SYS_RST) |-> O_POWER_DOWN && &O_ROUTING_CODES)
        else $error("reset state wrong");
    chk_idle_ctrl: assert property (I_CS_N [*8] |=> $stable({O_POWER_DOWN, O_POST_AMP_GAIN}))
        else $error("control moved while idle");
    chk_idle_route: assert property (idle_q > 4'h8 |-> $stable(O_ROUTING_CODES))
        else $error("routing moved while idle");
    cov_route: cover property ($changed(O_ROUTING_CODES));
    cov_power_up: cover property ($fell(O_POWER_DOWN));
    cov_all_routed: cover property (O_CH_TIED_SUPPLY == 8'h00);
endmodule
bind vsc_serial_port vsc_serial_port_monitor i_vsc_serial_port_monitor (
    .I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST),
    .I_CS_N(I_CS_N),
    .O_POWER_DOWN(O_POWER_DOWN),
    .O_ATTEN_RANGE_FIELD(O_ATTEN_RANGE_FIELD),
    .O_POST_AMP_GAIN(O_POST_AMP_GAIN),
    .O_MAX_ATTEN_TENTH_DB(O_MAX_ATTEN_TENTH_DB),
    .O_POST_AMP_GAIN_TENTH_DB(O_POST_AMP_GAIN_TENTH_DB),
    .O_ROUTING_CODES(O_ROUTING_CODES),
    .O_CW_CONNECT(O_CW_CONNECT),
    .O_CH_TIED_SUPPLY(O_CH_TIED_SUPPLY),
    .O_CROSSPOINT_ROUTING_CH7_CH8(O_CROSSPOINT_ROUTING_CH7_CH8)
);

// ===== sim/vsc_host_model.sv
`timescale 1ns/1ns
module vsc_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input wire logic i_dout
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    // free-running pulses only around reset
    task automatic pulse(input int n);
        repeat (n) begin
            #24 o_sclk = 1'b1;
            #24 o_sclk = 1'b0;
        end
    endtask
    task automatic frame(input logic [39:0] f, input int nbits, input logic keep_low,
            output logic [39:0] rd);
        rd = '0;
        o_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_din = f[i];
            #24 rd[i] = i_dout;
            o_sclk = 1'b1;
            #24 o_sclk = 1'b0;
        end
        o_din = ~o_din;
        #10 o_cs_n = !keep_low;
    endtask
endmodule

// ===== sim/vsc_serial_port_tb_top.sv
`timescale 1ns/1ns
module vsc_serial_port_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, din, dout, pwd, mode;
    logic [1:0] att, gain;
    logic [9:0] att_db, gain_db;
    logic [31:0] codes;
    logic [79:0] cw;
    logic [7:0] tied, b5;
    logic [39:0] rd, last_f;
    logic [31:0] exp_codes = 32'hFFFFFFFF;
    logic [9:0] atab [4] = '{10'h122, 10'h14A, 10'h16D, 10'h190};
    logic [9:0] gtab [4] = '{10'h0FA, 10'h12C, 10'h15E, 10'h190};
    int err_total = 0;
    int checks = 0;
    always #25 clk = ~clk;
    vsc_serial_port i_vsc_serial_port (.I_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_DIN(din), .O_DOUT(dout), .O_POWER_DOWN(pwd),
        .O_GAIN_RAMP_MODE(mode), .O_ATTEN_RANGE_FIELD(att), .O_POST_AMP_GAIN(gain),
        .O_MAX_ATTEN_TENTH_DB(att_db), .O_POST_AMP_GAIN_TENTH_DB(gain_db),
        .O_ROUTING_CODES(codes), .O_CW_CONNECT(cw), .O_CH_TIED_SUPPLY(tied),
        .O_CROSSPOINT_ROUTING_CH7_CH8(b5));
    vsc_host_model i_vsc_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic send_chk(input logic [7:0] c, input logic [31:0] d, input logic keep,
            input logic chk_rd);
        logic [79:0] ecw;
        logic [7:0] etie;
        logic [3:0] n;
        i_vsc_host_model.frame({d, c}, 40, keep, rd);
        repeat (8) @(posedge clk);
        if (chk_rd)
            cmp(rd, last_f);
        last_f = {d, c};
        exp_codes = c[1] ? d : exp_codes;
        ecw = '0;
        for (int ch = 0; ch < 8; ch++) begin
            n = exp_codes[ch*4+:4];
            etie[ch] = n > 4'h9;
            if (n <= 4'h9)
                ecw[ch*10+n] = 1'b1;
        end
        cmp({pwd, mode, att, gain}, {c[2], c[5], c[4:3], c[7:6]});
        cmp({att_db, gain_db}, {atab[c[4:3]], gtab[c[7:6]]});
        cmp(codes, exp_codes);
        cmp({cw, tied, b5}, {ecw, etie, exp_codes[31:24]});
    endtask
    task automatic t_reset;
        cmp({pwd, mode, att, gain, codes, tied, cw}, {6'h20, 32'hFFFFFFFF, 8'hFF, 80'h0});
        $display("done: reset");
    endtask
    task automatic t_codes;
        for (int i = 0; i < 4; i++)
            send_chk({i[1:0], i[0], i[1:0], i[0], 2'h3}, 32'h76543210 + i * 32'h88888888,
                1'b0, i > 0);
        $display("done: codes");
    endtask
    task automatic t_read;
        send_chk(8'h71, 32'h00000000, 1'b0, 1'b1);
        send_chk(8'hCB, 32'h0F1E2D3C, 1'b0, 1'b1);
        $display("done: read");
    endtask
    task automatic t_abort;
        i_vsc_host_model.frame(40'hA5A5A5A5A5, 20, 1'b0, rd);
        repeat (8) @(posedge clk);
        cmp({pwd, codes}, {1'b0, exp_codes});
        send_chk(8'h03, 32'h13579BDF, 1'b0, 1'b0);
        $display("done: abort");
    endtask
    task automatic t_cs_low;
        i_vsc_host_model.frame(40'h0, 3, 1'b1, rd);
        send_chk(8'hE7, 32'hCAFE0123, 1'b1, 1'b0);
        send_chk(8'h5B, 32'h02468ACE, 1'b0, 1'b1);
        $display("done: select low");
    endtask
    initial begin
        // link side needs serial clock edges to see the reset
        fork
            i_vsc_host_model.pulse(6);
            repeat (12) @(posedge clk);
        join
        rst <= 1'b0;
        i_vsc_host_model.pulse(4);
        t_reset();
        t_codes();
        t_read();
        t_abort();
        t_cs_low();
        wrap_up();
    end
    // eleven frames take about 23 us; allow a wide margin
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
